//--- rtl/sats_pkg.sv
// Purpose: Shared constants and state types of the smoke alarm timing sequencer
// Assumes: 100 MHz system clock; all slow timing counts in 500 us ticks
// Notes: Times are kept in microseconds except the clock and accelerated periods in nanoseconds; tick counts are derived from them
package sats_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_US = 500;
    localparam int TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int CNT_W = 17;
    localparam int SYNC_SETTLE = 3;

    localparam int T_PER_STBY_US = 1670000;
    localparam int T_PER_ALARM_US = 41500;
    localparam int T_STROBE_US = 10500;
    localparam int T_LED_STBY_US = 40000000;
    localparam int T_LED_ALARM_US = 1000000;
    localparam int T_LED_TIMER_US = 10000000;
    localparam int T_HORN_ON_US = 500000;
    localparam int T_HORN_OFF_US = 500000;
    localparam int T_HORN_LONG_US = 1500000;
    localparam int T_IO_DLY_US = 3000000;
    localparam int T_IO_DUMP_US = 1670000;
    localparam int T_IO_FILT_US = 1000000;
    localparam int T_ACCEL_PERIOD_NS = 250000;

    localparam logic [CNT_W-1:0] PER_STBY_TICKS = CNT_W'(T_PER_STBY_US / TICK_US);
    localparam logic [CNT_W-1:0] PER_ALARM_TICKS = CNT_W'(T_PER_ALARM_US / TICK_US);
    localparam logic [CNT_W-1:0] STROBE_TICKS = CNT_W'((T_STROBE_US + TICK_US - 1) / TICK_US);
    localparam logic [CNT_W-1:0] LED_STBY_TICKS = CNT_W'(T_LED_STBY_US / TICK_US);
    localparam logic [CNT_W-1:0] LED_ALARM_TICKS = CNT_W'(T_LED_ALARM_US / TICK_US);
    localparam logic [CNT_W-1:0] LED_TIMER_TICKS = CNT_W'(T_LED_TIMER_US / TICK_US);
    localparam logic [CNT_W-1:0] HORN_ON_TICKS = CNT_W'(T_HORN_ON_US / TICK_US);
    localparam logic [CNT_W-1:0] HORN_OFF_TICKS = CNT_W'(T_HORN_OFF_US / TICK_US);
    localparam logic [CNT_W-1:0] HORN_LONG_TICKS = CNT_W'(T_HORN_LONG_US / TICK_US);
    localparam logic [CNT_W-1:0] IO_DLY_TICKS = CNT_W'(T_IO_DLY_US / TICK_US);
    localparam logic [CNT_W-1:0] IO_DUMP_TICKS = CNT_W'(T_IO_DUMP_US / TICK_US);
    localparam logic [CNT_W-1:0] IO_FILT_TICKS = CNT_W'(T_IO_FILT_US / TICK_US);
    localparam int ACCEL_HALF_CYCLES = T_ACCEL_PERIOD_NS / 2 / CLK_PERIOD_NS;

    localparam logic [1:0] HORN_LAST_STEP = 2'h2;

    typedef enum logic [2:0] {
        LED_WAIT = 3'h1,
        LED_PULSE = 3'h2,
        LED_CHIRP = 3'h4
    } sats_led_t;

    typedef enum logic [2:0] {
        HORN_IDLE = 3'h1,
        HORN_ON = 3'h2,
        HORN_OFF = 3'h4
    } sats_horn_t;

    typedef enum logic [3:0] {
        IO_IDLE = 4'h1,
        IO_DELAY = 4'h2,
        IO_DRIVE = 4'h4,
        IO_DUMP = 4'h8
    } sats_io_t;

endpackage

//--- rtl/sats_link_if.sv
// Purpose: Shared pins between the alarm unit and an interconnected or test party
// Assumes: Line idles low through the unit's weak pull-down; timing node and feed idle high
// Notes: Wire levels are resolved here from the drivers' enables
`timescale 1ns/1ns
interface sats_link_if;
    logic dev_io_o;
    logic dev_io_oe;
    logic par_io_o;
    logic par_io_oe;
    logic par_node_o;
    logic par_node_oe;
    logic par_feed_o;
    logic par_feed_oe;
    logic io_level;
    logic node_level;
    logic feed_level;

    // High drive of either party wins; otherwise the line sits low
    assign io_level = (dev_io_oe & dev_io_o) | (par_io_oe & par_io_o);
    assign node_level = par_node_oe ? par_node_o : 1'b1;
    assign feed_level = par_feed_oe ? par_feed_o : 1'b1;

    modport dev (
        input io_level,
        input node_level,
        input feed_level,
        output dev_io_o,
        output dev_io_oe
    );

    modport par (
        input io_level,
        output par_io_o,
        output par_io_oe,
        output par_node_o,
        output par_node_oe,
        output par_feed_o,
        output par_feed_oe
    );
endinterface

//--- rtl/sats_device.sv
// Purpose: Timing and control sequencer of one ionization smoke alarm unit
// Assumes: Comparator and pin levels are asynchronous and are synchronised here
// Notes: Slow timing runs on a 500 us tick from a prescaler
`timescale 1ns/1ns
module sats_device #(
    parameter int TICK_CYCLES = sats_pkg::TICK_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic smoke_cmp_i,
    input wire logic lowbat_cmp_i,
    input wire logic timer_mode_i,
    sats_link_if.dev link,
    output logic power_strobe_o,
    output logic led_o,
    output logic horn_bridge_output_o,
    output logic local_alarm_o,
    output logic remote_alarm_o,
    output logic low_battery_o
);
    localparam int PRE_W = $clog2(TICK_CYCLES);
    localparam int W = sats_pkg::CNT_W;

    if (TICK_CYCLES < 2) begin : g_chk
        $error("TICK_CYCLES must be at least 2");
    end

    logic [4:0] sync1, sync2;
    logic node_d;
    logic io_s, node_s, feed_s, smoke_s, lowbat_s;
    logic [PRE_W-1:0] pre_cnt, next_pre_cnt;
    logic tick;
    logic [1:0] settle, next_settle;
    logic pu_test, next_pu_test;
    logic low_all, next_low_all, held, next_held;
    logic [W-1:0] osc_cnt, next_osc_cnt, osc_len;
    logic strobe_on, strobe_end, node_rise;
    logic smoke, next_smoke, lowbat, next_lowbat;
    logic [W-1:0] flt_cnt, next_flt_cnt;
    logic remote, alarm;
    sats_pkg::sats_led_t led_st, next_led_st;
    logic [W-1:0] led_cnt, next_led_cnt, led_len;
    sats_pkg::sats_horn_t horn_st, next_horn_st;
    logic [W-1:0] horn_cnt, next_horn_cnt;
    logic [1:0] step, next_step;
    logic cyc_local, next_cyc_local;
    sats_pkg::sats_io_t io_st, next_io_st;
    logic [W-1:0] io_cnt, next_io_cnt;

    // Two-flop synchronisers, then one extra stage for node edge detection
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sync1 <= 5'h1F;
            sync2 <= 5'h1F;
            node_d <= 1'b1;
        end else begin
            sync1 <= {link.io_level, link.node_level, link.feed_level, smoke_cmp_i, lowbat_cmp_i};
            sync2 <= sync1;
            node_d <= sync2[3];
        end
    end
    assign io_s = sync2[4];
    assign node_s = sync2[3];
    assign feed_s = sync2[2];
    assign smoke_s = sync2[1];
    assign lowbat_s = sync2[0];
    assign node_rise = node_s & ~node_d;

    // Prescaler and power-up test capture once the synchronisers have settled
    always_comb begin
        next_pre_cnt = (pre_cnt == PRE_W'(TICK_CYCLES - 1)) ? '0 : pre_cnt + PRE_W'(1);
        if (node_rise & ~strobe_on) begin
            next_pre_cnt = '0;
        end
        // Node counts as held low only after a whole tick low, so a fast square wave does not
        next_low_all = tick ? ~node_s : (low_all & ~node_s);
        next_held = ~node_s & (held | (tick & low_all));
        next_settle = settle;
        next_pu_test = pu_test;
        if (settle != 2'(sats_pkg::SYNC_SETTLE)) begin
            next_settle = settle + 2'h1;
            if (settle == 2'(sats_pkg::SYNC_SETTLE - 1)) begin
                next_pu_test = ~feed_s & ~node_s;
            end
        end else if (node_s) begin
            next_pu_test = 1'b0;
        end
    end
    assign tick = (pre_cnt == PRE_W'(TICK_CYCLES - 1));

    // Oscillator period and sensing strobe
    always_comb begin
        osc_len = alarm ? sats_pkg::PER_ALARM_TICKS : sats_pkg::PER_STBY_TICKS;
        strobe_on = (osc_cnt < sats_pkg::STROBE_TICKS);
        strobe_end = tick & (osc_cnt == sats_pkg::STROBE_TICKS - W'(1));
        next_osc_cnt = osc_cnt;
        if (node_rise & ~strobe_on) begin
            next_osc_cnt = '0;
        end else if (tick) begin
            next_osc_cnt = (osc_cnt >= osc_len - W'(1)) ? '0 : osc_cnt + W'(1);
        end
        next_smoke = smoke;
        if (strobe_end & (led_st == sats_pkg::LED_WAIT) & (horn_st != sats_pkg::HORN_ON)) begin
            next_smoke = smoke_s;
        end
    end

    // Interconnect input filter
    always_comb begin
        next_flt_cnt = flt_cnt;
        if (~io_s | smoke) begin
            next_flt_cnt = '0;
        end else if (tick & (flt_cnt != sats_pkg::IO_FILT_TICKS)) begin
            next_flt_cnt = flt_cnt + W'(1);
        end
    end
    assign remote = ~smoke & (flt_cnt == sats_pkg::IO_FILT_TICKS);
    assign alarm = smoke | remote;

    // LED pulse, battery test and chirp
    always_comb begin
        if (smoke) begin
            led_len = sats_pkg::LED_ALARM_TICKS;
        end else if (timer_mode_i) begin
            led_len = sats_pkg::LED_TIMER_TICKS;
        end else begin
            led_len = sats_pkg::LED_STBY_TICKS;
        end
        next_led_st = led_st;
        next_led_cnt = led_cnt;
        next_lowbat = lowbat;
        case (led_st)
            sats_pkg::LED_WAIT: begin
                if (tick) begin
                    next_led_cnt = led_cnt + W'(1);
                    if (led_cnt >= led_len - W'(1)) begin
                        next_led_cnt = '0;
                        if (~remote) begin
                            next_led_st = sats_pkg::LED_PULSE;
                        end
                    end
                end
            end
            sats_pkg::LED_PULSE: begin
                if (tick) begin
                    next_led_cnt = led_cnt + W'(1);
                    if (led_cnt == sats_pkg::STROBE_TICKS - W'(1)) begin
                        next_led_cnt = '0;
                        next_led_st = sats_pkg::LED_WAIT;
                        if (~alarm) begin
                            next_lowbat = lowbat_s;
                            if (lowbat_s) begin
                                next_led_st = sats_pkg::LED_CHIRP;
                            end
                        end
                    end
                end
            end
            sats_pkg::LED_CHIRP: begin
                if (alarm) begin
                    next_led_cnt = '0;
                    next_led_st = sats_pkg::LED_WAIT;
                end else if (tick) begin
                    next_led_cnt = led_cnt + W'(1);
                    if (led_cnt == sats_pkg::STROBE_TICKS - W'(1)) begin
                        next_led_cnt = '0;
                        next_led_st = sats_pkg::LED_WAIT;
                    end
                end
            end
            default: begin
                next_led_cnt = '0;
                next_led_st = sats_pkg::LED_WAIT;
            end
        endcase
    end

    // Temporal horn pattern
    always_comb begin
        next_horn_st = horn_st;
        next_horn_cnt = horn_cnt;
        next_step = step;
        next_cyc_local = cyc_local | smoke;
        case (horn_st)
            sats_pkg::HORN_IDLE: begin
                if (alarm) begin
                    next_horn_st = sats_pkg::HORN_ON;
                    next_horn_cnt = '0;
                    next_step = '0;
                    next_cyc_local = smoke;
                end
            end
            sats_pkg::HORN_ON: begin
                if (tick) begin
                    next_horn_cnt = horn_cnt + W'(1);
                    if (horn_cnt == sats_pkg::HORN_ON_TICKS - W'(1)) begin
                        next_horn_cnt = '0;
                        next_horn_st = sats_pkg::HORN_OFF;
                    end
                end
            end
            sats_pkg::HORN_OFF: begin
                if (tick) begin
                    next_horn_cnt = horn_cnt + W'(1);
                    if ((step == sats_pkg::HORN_LAST_STEP) ? (horn_cnt == sats_pkg::HORN_LONG_TICKS - W'(1))
                                                           : (horn_cnt == sats_pkg::HORN_OFF_TICKS - W'(1))) begin
                        next_horn_cnt = '0;
                        next_step = step + 2'h1;
                        next_horn_st = sats_pkg::HORN_ON;
                        if (step == sats_pkg::HORN_LAST_STEP) begin
                            next_step = '0;
                            next_cyc_local = smoke;
                            next_horn_st = alarm ? sats_pkg::HORN_ON : sats_pkg::HORN_IDLE;
                        end
                    end
                end
            end
            default: begin
                next_horn_st = sats_pkg::HORN_IDLE;
            end
        endcase
        if (~alarm & ~cyc_local) begin
            next_horn_st = sats_pkg::HORN_IDLE;
            next_horn_cnt = '0;
            next_step = '0;
        end
    end

    // Interconnect drive and discharge
    always_comb begin
        next_io_st = io_st;
        next_io_cnt = io_cnt;
        case (io_st)
            sats_pkg::IO_IDLE: begin
                if (smoke) begin
                    next_io_st = sats_pkg::IO_DELAY;
                    next_io_cnt = '0;
                end
            end
            sats_pkg::IO_DELAY: begin
                if (~smoke) begin
                    next_io_st = sats_pkg::IO_DUMP;
                    next_io_cnt = '0;
                end else if (tick) begin
                    next_io_cnt = io_cnt + W'(1);
                    if (io_cnt == sats_pkg::IO_DLY_TICKS - W'(1)) begin
                        next_io_st = sats_pkg::IO_DRIVE;
                    end
                end
            end
            sats_pkg::IO_DRIVE: begin
                if (~smoke) begin
                    next_io_st = sats_pkg::IO_DUMP;
                    next_io_cnt = '0;
                end
            end
            sats_pkg::IO_DUMP: begin
                if (smoke) begin
                    next_io_st = sats_pkg::IO_DELAY;
                    next_io_cnt = '0;
                end else if (tick) begin
                    next_io_cnt = io_cnt + W'(1);
                    if (io_cnt == sats_pkg::IO_DUMP_TICKS - W'(1)) begin
                        next_io_st = sats_pkg::IO_IDLE;
                    end
                end
            end
            default: begin
                next_io_st = sats_pkg::IO_IDLE;
            end
        endcase
    end

    // State and registered outputs
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pre_cnt <= '0;
            settle <= '0;
            pu_test <= 1'b0;
            low_all <= 1'b0;
            held <= 1'b0;
            osc_cnt <= '0;
            smoke <= 1'b0;
            lowbat <= 1'b0;
            flt_cnt <= '0;
            led_st <= sats_pkg::LED_WAIT;
            led_cnt <= '0;
            horn_st <= sats_pkg::HORN_IDLE;
            horn_cnt <= '0;
            step <= '0;
            cyc_local <= 1'b0;
            io_st <= sats_pkg::IO_IDLE;
            io_cnt <= '0;
            power_strobe_o <= 1'b0;
            led_o <= 1'b0;
            horn_bridge_output_o <= 1'b0;
            local_alarm_o <= 1'b0;
            remote_alarm_o <= 1'b0;
            low_battery_o <= 1'b0;
            link.dev_io_o <= 1'b0;
            link.dev_io_oe <= 1'b0;
        end else begin
            pre_cnt <= next_pre_cnt;
            settle <= next_settle;
            pu_test <= next_pu_test;
            low_all <= next_low_all;
            held <= next_held;
            osc_cnt <= next_osc_cnt;
            smoke <= next_smoke;
            lowbat <= next_lowbat;
            flt_cnt <= next_flt_cnt;
            led_st <= next_led_st;
            led_cnt <= next_led_cnt;
            horn_st <= next_horn_st;
            horn_cnt <= next_horn_cnt;
            step <= next_step;
            cyc_local <= next_cyc_local;
            io_st <= next_io_st;
            io_cnt <= next_io_cnt;
            power_strobe_o <= strobe_on | held;
            led_o <= (led_st == sats_pkg::LED_PULSE);
            horn_bridge_output_o <= pu_test ? lowbat_s
                : ((horn_st == sats_pkg::HORN_ON) | (led_st == sats_pkg::LED_CHIRP));
            local_alarm_o <= smoke;
            remote_alarm_o <= remote;
            low_battery_o <= lowbat;
            link.dev_io_o <= (io_st == sats_pkg::IO_DRIVE);
            link.dev_io_oe <= (io_st == sats_pkg::IO_DRIVE) | (io_st == sats_pkg::IO_DUMP);
        end
    end
endmodule

//--- rtl/sats_partner.sv
// Purpose: Far party of the shared pins: an interconnected unit or a tester
// Assumes: Request inputs come from logic on the same clock
// Notes: Accelerated mode drives the timing node with a square wave
`timescale 1ns/1ns
module sats_partner #(
    parameter int ACCEL_HALF_CYCLES = sats_pkg::ACCEL_HALF_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic alarm_req_i,
    input wire logic hold_node_low_i,
    input wire logic accel_i,
    input wire logic hold_feed_low_i,
    sats_link_if.par link,
    output logic line_active_o
);
    localparam int DIV_W = $clog2(ACCEL_HALF_CYCLES);

    if (ACCEL_HALF_CYCLES < 2) begin : g_chk
        $error("ACCEL_HALF_CYCLES must be at least 2");
    end

    logic [DIV_W-1:0] div_cnt, next_div_cnt;
    logic sq, next_sq;
    logic io_m, io_s;

    always_comb begin
        next_div_cnt = div_cnt + DIV_W'(1);
        next_sq = sq;
        if (~accel_i) begin
            next_div_cnt = '0;
            next_sq = 1'b0;
        end else if (div_cnt == DIV_W'(ACCEL_HALF_CYCLES - 1)) begin
            next_div_cnt = '0;
            next_sq = ~sq;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            div_cnt <= '0;
            sq <= 1'b0;
            io_m <= 1'b0;
            io_s <= 1'b0;
            line_active_o <= 1'b0;
            link.par_io_o <= 1'b0;
            link.par_io_oe <= 1'b0;
            // Tester holds apply through reset so the power-up test sees them
            link.par_node_o <= 1'b0;
            link.par_node_oe <= hold_node_low_i | accel_i;
            link.par_feed_o <= 1'b0;
            link.par_feed_oe <= hold_feed_low_i;
        end else begin
            div_cnt <= next_div_cnt;
            sq <= next_sq;
            io_m <= link.io_level;
            io_s <= io_m;
            line_active_o <= io_s;
            link.par_io_o <= alarm_req_i;
            link.par_io_oe <= alarm_req_i;
            link.par_node_o <= accel_i & sq;
            link.par_node_oe <= hold_node_low_i | accel_i;
            link.par_feed_o <= 1'b0;
            link.par_feed_oe <= hold_feed_low_i;
        end
    end
endmodule

//--- dv/sats_sva.sv
// Purpose: Concurrent checks on the alarm unit outputs and the shared line
// Assumes: One clock domain; TICK_CYCLES matches the device instance
// Notes: Long counts are kept in helper counters
`timescale 1ns/1ns
module sats_sva #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic dev_io_o,
    input wire logic dev_io_oe,
    input wire logic io_level,
    input wire logic node_level,
    input wire logic power_strobe_o,
    input wire logic led_o,
    input wire logic horn_bridge_output_o,
    input wire logic local_alarm_o,
    input wire logic remote_alarm_o
);
    localparam int T = TICK_CYCLES;
    int led_len = 0;
    int horn_len = 0;
    int dump_len = 0;
    int high_len = 0;
    int alarm_len = 0;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    always_ff @(posedge clk_sys_i) begin
        led_len <= (led_o && !rst_i) ? led_len + 1 : 0;
        horn_len <= (horn_bridge_output_o && !rst_i) ? horn_len + 1 : 0;
        dump_len <= (dev_io_oe && !dev_io_o && !rst_i) ? dump_len + 1 : 0;
        high_len <= (io_level && !rst_i) ? high_len + 1 : 0;
        alarm_len <= (local_alarm_o && !rst_i) ? alarm_len + 1 : 0;
    end

    sequence s_horn_up;
        ##[0:8] horn_bridge_output_o;
    endsequence
    sequence s_dump_hold;
        dev_io_oe ##1 (dev_io_oe && !dev_io_o) [*8];
    endsequence

    a_led_pulse_width: assert property ($fell(led_o) |-> led_len == 21 * T)
        else $error("LED pulse width wrong");
    a_horn_on_time: assert property ($fell(horn_bridge_output_o) && local_alarm_o
        |-> horn_len >= 1000 * T - T && horn_len <= 1000 * T)
        else $error("horn on time wrong");
    a_horn_starts_local: assert property ($rose(local_alarm_o) |-> s_horn_up)
        else $error("horn late after local alarm");
    a_horn_starts_remote: assert property ($rose(remote_alarm_o) |-> s_horn_up)
        else $error("horn late after remote alarm");
    a_line_drive_delay: assert property ($rose(dev_io_o && dev_io_oe)
        |-> local_alarm_o && alarm_len >= 5998 * T && alarm_len <= 6002 * T)
        else $error("line drive delay wrong");
    a_dump_follows_drive: assert property ($fell(dev_io_o) |-> s_dump_hold)
        else $error("discharge does not follow drive");
    a_dump_length: assert property ($fell(dev_io_oe) |-> dump_len >= 3339 * T && dump_len <= 3341 * T)
        else $error("discharge length wrong");
    a_remote_filter: assert property ($rose(remote_alarm_o)
        |-> !local_alarm_o && high_len >= 1998 * T && high_len <= 2004 * T)
        else $error("line filter time wrong");
    a_no_led_remote: assert property (remote_alarm_o && !local_alarm_o |-> !$rose(led_o))
        else $error("LED pulse in remote alarm");
    a_strobe_node_low: assert property ((!node_level) [*5] |-> power_strobe_o)
        else $error("strobe off with node low");
endmodule

//--- dv/sats_tb.sv
// Purpose: Self-checking bench joining one alarm unit and its far party
// Assumes: Tick shortened to 2 clocks; far party on the same clock
// Notes: Widths and gaps are counted in clocks against the tick counts
`timescale 1ns/1ns
module sats_tb;
    localparam int T = 2;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic smoke_cmp_i = 1'b0;
    logic lowbat_cmp_i = 1'b0;
    logic timer_mode_i = 1'b0;
    logic alarm_req_i = 1'b0;
    logic hold_node_low_i = 1'b1;
    logic accel_i = 1'b0;
    logic hold_feed_low_i = 1'b1;
    logic power_strobe_o, led_o, horn_bridge_output_o, local_alarm_o, remote_alarm_o, low_battery_o;
    logic line_active_o;
    logic bit_v;
    int miscompares = 0;
    int samples_checked = 0;
    int gap, len, on_e, off_e;
    int last_led = 0;
    int led_gaps[$];

    sats_link_if link();
    sats_device #(.TICK_CYCLES(T)) i_sats_device (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .smoke_cmp_i(smoke_cmp_i), .lowbat_cmp_i(lowbat_cmp_i), .timer_mode_i(timer_mode_i), .link(link),
        .power_strobe_o(power_strobe_o), .led_o(led_o), .horn_bridge_output_o(horn_bridge_output_o),
        .local_alarm_o(local_alarm_o), .remote_alarm_o(remote_alarm_o), .low_battery_o(low_battery_o));
    sats_partner #(.ACCEL_HALF_CYCLES(2)) i_sats_partner (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .alarm_req_i(alarm_req_i), .hold_node_low_i(hold_node_low_i), .accel_i(accel_i),
        .hold_feed_low_i(hold_feed_low_i), .link(link), .line_active_o(line_active_o));
    sats_sva #(.TICK_CYCLES(T)) i_sats_sva (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .dev_io_o(link.dev_io_o),
        .dev_io_oe(link.dev_io_oe), .io_level(link.io_level), .node_level(link.node_level),
        .power_strobe_o(power_strobe_o), .led_o(led_o), .horn_bridge_output_o(horn_bridge_output_o),
        .local_alarm_o(local_alarm_o), .remote_alarm_o(remote_alarm_o));

    always #5 clk_sys_i = ~clk_sys_i;

    // Model of the alarm LED rate: gaps between pulses while the unit originates the alarm
    always @(posedge clk_sys_i) begin
        if (local_alarm_o === 1'b1 && $rose(led_o)) begin
            if (last_led > 0) begin
                led_gaps.push_back(int'($time / 10) - last_led);
            end
            last_led = int'($time / 10);
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_len(input int got, input int lo, input int hi, input string what);
        samples_checked++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("mismatch at %0t: %s got %0d not in %0d..%0d", $time, what, got, lo, hi);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    function automatic logic pick(input int which);
        return which == 0 ? power_strobe_o : (which == 1 ? led_o : horn_bridge_output_o);
    endfunction

    // Skips a pulse in progress, then counts the low gap and the next high pulse
    task automatic wait_pulse(input int which, input int limit, output int gap_c, output int len_c);
        gap_c = 0;
        len_c = 0;
        while (pick(which) === 1'b1 && len_c < limit) begin
            cycles(1);
            len_c++;
        end
        len_c = 0;
        while (pick(which) !== 1'b1 && gap_c < limit) begin
            cycles(1);
            gap_c++;
        end
        while (pick(which) === 1'b1 && len_c < limit) begin
            cycles(1);
            len_c++;
        end
        if (len_c >= limit) begin
            miscompares++;
            test_done();
        end
    endtask

    initial begin
        #980000;
        miscompares++;
        test_done();
    end

    initial begin
        gap = $urandom(32'h0731);
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        cycles(1);
        chk_bit(local_alarm_o, 1'b0, "local after reset");
        chk_bit(link.dev_io_oe, 1'b0, "line drive after reset");
        cycles(6);
        chk_bit(power_strobe_o, 1'b1, "strobe with node low");
        for (int i = 0; i < 6; i++) begin
            bit_v = 1'($urandom());
            @(posedge clk_sys_i);
            lowbat_cmp_i <= bit_v;
            cycles(8);
            chk_bit(horn_bridge_output_o, bit_v, "horn follows battery");
        end
        @(posedge clk_sys_i);
        lowbat_cmp_i <= 1'b0;
        hold_node_low_i <= 1'b0;
        hold_feed_low_i <= 1'b0;
        accel_i <= 1'b1;
        wait_pulse(0, 20000, gap, len);
        chk_len(len, 21 * T, 21 * T, "strobe width fast node");
        @(posedge clk_sys_i);
        accel_i <= 1'b0;
        wait_pulse(0, 20000, gap, len);
        wait_pulse(0, 20000, gap, len);
        chk_len(gap, 3319 * T - T, 3319 * T + T, "standby strobe gap");
        chk_len(len, 21 * T, 21 * T, "standby strobe width");
        $display("test power_up done");
        @(posedge clk_sys_i);
        smoke_cmp_i <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            if (i == 4) begin
                chk_bit(link.dev_io_o, 1'b1, "line driven in alarm");
                @(posedge clk_sys_i);
                smoke_cmp_i <= 1'b0;
            end
            wait_pulse(2, 20000, gap, len);
            on_e = (i < 6) ? 1000 * T : 0;
            off_e = (i % 3 == 0) ? 3000 * T : 1000 * T;
            chk_len(len, on_e - T, on_e + T, "horn on time");
            if (i > 0 && i < 6) begin
                chk_len(gap, off_e - T, off_e + T, "horn off time");
            end
        end
        chk_bit(local_alarm_o, 1'b0, "local alarm cleared");
        chk_bit(link.dev_io_oe, 1'b0, "line released after discharge");
        chk_len(led_gaps.size(), 1, 100, "alarm LED pulses seen");
        foreach (led_gaps[k]) begin
            chk_len(led_gaps[k], 2021 * T - T, 2021 * T + T, "alarm LED interval");
        end
        $display("test local_alarm done");
        @(posedge clk_sys_i);
        alarm_req_i <= 1'b1;
        cycles(1000);
        chk_bit(line_active_o, 1'b1, "line seen high");
        @(posedge clk_sys_i);
        alarm_req_i <= 1'b0;
        cycles(3000);
        chk_bit(remote_alarm_o, 1'b0, "short pulse rejected");
        @(posedge clk_sys_i);
        alarm_req_i <= 1'b1;
        wait_pulse(2, 20000, gap, len);
        chk_len(gap, 900 * T, 4400 * T, "remote horn delay");
        chk_len(len, 1000 * T - T, 1000 * T + T, "remote horn on");
        cycles(6000);
        @(posedge clk_sys_i);
        alarm_req_i <= 1'b0;
        cycles(50);
        chk_bit(remote_alarm_o, 1'b0, "remote cleared");
        chk_bit(horn_bridge_output_o, 1'b0, "horn stops with remote");
        chk_bit(link.dev_io_oe, 1'b0, "no discharge after remote");
        $display("test remote_alarm done");
        test_done();
    end
endmodule
